// ===== logic/tdmtsa_pkg.sv
// Purpose: shared constants, types and helpers of the timeslot assigner
// Assumes: 20 MHz system clock, stream rates set by the host
// Notes: slot shift gives log2 of slots per stream
package tdmtsa_pkg;
  // shared memory words published to the host
  localparam logic [12:0] SHM_COUNT_ADDR = 13'h1f10;
  localparam logic [12:0] SHM_BASE_ADDR = 13'h1f12;
  // channels per span, spans start every 20h
  localparam logic [4:0] T1_CHANS = 5'h18;
  localparam logic [4:0] PRI_CHANS = 5'h17;
  // stream counts per bus flavour
  localparam logic [5:0] NATIVE_STREAMS = 6'h20;
  localparam logic [5:0] LEGACY_STREAMS = 6'h10;
  localparam logic [5:0] HS_STREAMS = 6'h18;
  // log2 of slots per stream: 32, 64, 128
  localparam logic [2:0] SHIFT_2M = 3'h5;
  localparam logic [2:0] SHIFT_4M = 3'h6;
  localparam logic [2:0] SHIFT_8M = 3'h7;
  // storage sizes
  localparam int CONN_DEPTH = 4096;
  localparam int RSP_DEPTH = 4;
  localparam int RSP_WIDTH = 21;
  localparam logic [11:0] CONN_LAST = 12'hfff;

  typedef enum logic [1:0] {
    RATE_2M = 2'h0,
    RATE_4M = 2'h1,
    RATE_8M = 2'h2
  } tdmtsa_rate_type;

  typedef enum logic [2:0] {
    MODE_NATIVE = 3'h0,
    MODE_SC16 = 3'h1,
    MODE_PAIRED16 = 3'h2,
    MODE_HS_COMPAT = 3'h3,
    MODE_HS_FULL = 3'h4
  } tdmtsa_mode_type;

  typedef enum logic [2:0] {
    OP_RESERVE = 3'h0,
    OP_QUERY = 3'h1,
    OP_RATE = 3'h2,
    OP_OUTPUT = 3'h3,
    OP_DETECT = 3'h4
  } tdmtsa_op_type;

  typedef enum logic [1:0] {
    ST_CLEAR = 2'h0,
    ST_IDLE = 2'h1,
    ST_EXEC = 2'h3
  } tdmtsa_st_type;

  // slots per stream as a shift, by bus mode, rate and stream
  function automatic logic [2:0] slotShift(input logic [2:0] mode,
                                           input logic [1:0] rate,
                                           input logic [4:0] stream);
    logic [2:0] sh;
    sh = SHIFT_8M;
    if (stream < LEGACY_STREAMS[4:0]) begin
      case (mode)
        MODE_PAIRED16, MODE_HS_COMPAT: sh = SHIFT_2M;
        MODE_SC16: sh = (rate == RATE_2M) ? SHIFT_2M :
                        (rate == RATE_4M) ? SHIFT_4M : SHIFT_8M;
        default: sh = SHIFT_8M;
      endcase
    end
    return sh;
  endfunction : slotShift

  // number of streams usable in a bus mode
  function automatic logic [5:0] streamLimit(input logic [2:0] mode);
    logic [5:0] lim;
    case (mode)
      MODE_SC16, MODE_PAIRED16: lim = LEGACY_STREAMS;
      MODE_HS_COMPAT, MODE_HS_FULL: lim = HS_STREAMS;
      default: lim = NATIVE_STREAMS;
    endcase
    return lim;
  endfunction : streamLimit
endpackage : tdmtsa_pkg

// ===== logic/tdmtsa_fifo.sv
// Purpose: small valid/ready fifo for reply words
// Assumes: depth is a power of two
// Notes: full and empty come straight from the fill count
`timescale 1ns/100ps
module tdmtsa_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // draining side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } tdmtsa_fifo_state_type;

  tdmtsa_fifo_state_type s_ff, nxt_s;
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic push, pop;

  // handshakes from the fill count
  assign inReady = (s_ff.cnt != FULL_CNT);
  assign outValid = (s_ff.cnt != '0);
  assign outData = mem[s_ff.rd];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // pointer and count update
  always_comb begin
    nxt_s = s_ff;
    if (push) nxt_s.wr = s_ff.wr + 1'b1;
    if (pop) nxt_s.rd = s_ff.rd + 1'b1;
    if (push && !pop) nxt_s.cnt = s_ff.cnt + 1'b1;
    if (pop && !push) nxt_s.cnt = s_ff.cnt - 1'b1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) s_ff <= '0;
    else s_ff <= nxt_s;
  end

  // storage needs no reset, guarded by the count
  always_ff @(posedge clk) begin
    if (push) mem[s_ff.wr] <= inData;
  end
endmodule : tdmtsa_fifo

// ===== logic/tdmtsa_range.sv
// Purpose: checks a stream/timeslot pair against the bus setup
// Assumes: mode and rate come from registered configuration
// Notes: purely combinational
`timescale 1ns/100ps
module tdmtsa_range (
  // configuration
  input wire logic [2:0] mode,
  input wire logic [1:0] rate,
  // argument under test
  input wire logic [4:0] stream,
  input wire logic [6:0] slot,
  // verdict
  output logic ok
);
  logic [2:0] sh;
  logic [7:0] slots;

  // slots per stream shrink on slow legacy streams
  assign sh = tdmtsa_pkg::slotShift(mode, rate, stream);
  assign slots = 8'h01 << sh;
  assign ok = ({1'b0, stream} < tdmtsa_pkg::streamLimit(mode)) &&
              ({1'b0, slot} < slots);
endmodule : tdmtsa_range

// ===== logic/tdmtsa_top.sv
// Purpose: timeslot assigner and connection scanner of the bus interface
// Assumes: host commands arrive already decoded, one at a time
// Notes: reply words pass a four-word fifo; queries stall on it
// Contract
// - span channel numbers start every 20h
// - T1 spans give 24 channel numbers
// - PRI spans keep top channel as D
// - stream field 00-1F, then timeslot field
// - native streams carry 128 timeslots
// - legacy buses use only first 16 streams
// - 4.096 gives 64, 2.048 gives 32 slots
// - host sets lower stream rate; device follows
// - reserve stores base of first port
// - reserved base plus port overrides explicit slot
// - publish count at reserved_timeslot_count, base first_assigned_timeslot
// - query replies port, stream, timeslot
// - query without reservation replies Z
// - paired legacy bus: 32 slots at 2.048
// - unenabled output timeslots stay undriven
// - high-speed bus: compatible or all-fast mode
// - detect command does the whole job
// - every port gets unique transmit timeslot
`timescale 1ns/100ps
module tdmtsa_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // span framing straps, high for primary rate
  input wire logic [7:0] spanPri,
  // command request
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [2:0] cmdOp,
  input wire logic [7:0] cmdPort,
  input wire logic [4:0] cmdStream,
  input wire logic [6:0] cmdSlot,
  input wire logic [15:0] cmdCount,
  input wire logic cmdEnable,
  input wire logic [1:0] cmdRate,
  input wire logic [2:0] cmdMode,
  // command outcome
  output logic cmdDone,
  output logic cmdReject,
  // query reply
  output logic rspValid,
  input wire logic rspReady,
  output logic rspNone,
  output logic [7:0] rspPort,
  output logic [4:0] rspStream,
  output logic [6:0] rspSlot,
  // shared memory read
  input wire logic shmRd,
  input wire logic [12:0] shmAddr,
  output logic [15:0] shmData,
  // tone and detector resources
  output logic toneOn,
  output logic detArm,
  output logic [7:0] resPort,
  // bus drive scan
  output logic [4:0] txStream,
  output logic [6:0] txSlot,
  output logic txOe,
  output logic [7:0] txPort,
  // configuration in force
  output logic [1:0] lowRate,
  output logic [2:0] busMode
);
  typedef struct packed {
    tdmtsa_pkg::tdmtsa_st_type st;
    logic [2:0] op;
    logic [7:0] port;
    logic [4:0] strm;
    logic [6:0] slot;
    logic [15:0] cnt;
    logic en;
    logic [1:0] rate;
    logic [2:0] mode;
    logic baseOk;
    logic [3:0] baseStrm;
    logic [6:0] baseSlot;
    logic [15:0] resCnt;
    logic [1:0] lowRate;
    logic [2:0] busMode;
    logic [7:0] priS1;
    logic [7:0] priS2;
    logic [11:0] clrAddr;
    logic [11:0] scanPos;
    logic [11:0] txPos;
    logic txOe;
    logic [7:0] txPort;
    logic [15:0] shmData;
    logic done;
    logic rej;
    logic toneOn;
    logic detArm;
    logic [7:0] resPort;
  } tdmtsa_state_type;

  tdmtsa_state_type s_ff, nxt_s;
  logic [8:0] connMem [0:tdmtsa_pkg::CONN_DEPTH-1];

  logic [2:0] spanIdx, baseShift, scanShift;
  logic [4:0] chan, tgtStrm, rngStrm, scanStrm;
  logic [6:0] tgtSlot, rngSlot, scanSlot;
  logic [12:0] baseAbs, tgtAbs;
  logic [11:0] tgtAddr, memAddr;
  logic [8:0] connRd, scanRd, memData;
  logic chanOk, rngOk, collide, memWe, isExec;
  logic rspInValid, rspInReady;
  logic [tdmtsa_pkg::RSP_WIDTH-1:0] rspInData, rspOutData;

  // channel number split into span and channel within span
  assign spanIdx = s_ff.port[7:5];
  assign chan = s_ff.port[4:0];
  // primary rate spans lose the top channel to signalling
  assign chanOk = chan < (s_ff.priS2[spanIdx] ? tdmtsa_pkg::PRI_CHANS :
                                                tdmtsa_pkg::T1_CHANS);

  // base and port summed in the stream's own slot count
  assign baseShift = tdmtsa_pkg::slotShift(s_ff.busMode, s_ff.lowRate,
                                           {1'b0, s_ff.baseStrm});
  assign baseAbs = (13'(s_ff.baseStrm) << baseShift) |
                   13'(s_ff.baseSlot);
  assign tgtAbs = baseAbs + 13'(s_ff.port);
  assign tgtStrm = 5'(tgtAbs >> baseShift);
  assign tgtSlot = 7'(tgtAbs & ((13'h0001 << baseShift) - 13'h0001));

  // reserve and unreserved outputs test the typed argument
  always_comb begin
    if (s_ff.op == tdmtsa_pkg::OP_RESERVE || !s_ff.baseOk) begin
      rngStrm = s_ff.strm;
      rngSlot = s_ff.slot;
    end else begin
      rngStrm = tgtStrm;
      rngSlot = tgtSlot;
    end
  end

  tdmtsa_range u_range (
    .mode(s_ff.busMode),
    .rate(s_ff.lowRate),
    .stream(rngStrm),
    .slot(rngSlot),
    .ok(rngOk)
  );

  // a slot held by another port must not get a second talker
  assign tgtAddr = {rngStrm, rngSlot};
  assign connRd = connMem[tgtAddr];
  assign collide = connRd[8] && (connRd[7:0] != s_ff.port) && s_ff.en;
  assign isExec = (s_ff.st == tdmtsa_pkg::ST_EXEC);

  // scan position walks the slots that exist per stream, save one stale position after a mode change
  assign scanStrm = s_ff.scanPos[11:7];
  assign scanSlot = s_ff.scanPos[6:0];
  assign scanShift = tdmtsa_pkg::slotShift(s_ff.busMode, s_ff.lowRate,
                                           scanStrm);
  assign scanRd = connMem[s_ff.scanPos];

  // reply word carries the queried port even when unreserved
  assign rspInData = {!s_ff.baseOk, s_ff.port, tgtStrm, tgtSlot};
  assign rspInValid = isExec && s_ff.op == tdmtsa_pkg::OP_QUERY && chanOk;

  tdmtsa_fifo #(
    .WIDTH(tdmtsa_pkg::RSP_WIDTH),
    .DEPTH(tdmtsa_pkg::RSP_DEPTH)
  ) u_rsp_fifo (
    .clk(clk),
    .rst(rst),
    .inValid(rspInValid),
    .inReady(rspInReady),
    .inData(rspInData),
    .outValid(rspValid),
    .outReady(rspReady),
    .outData(rspOutData)
  );

  // next state of the whole block
  always_comb begin
    nxt_s = s_ff;
    memWe = 1'b0;
    memAddr = tgtAddr;
    memData = {s_ff.en, s_ff.port};
    nxt_s.done = 1'b0;
    nxt_s.rej = 1'b0;
    nxt_s.toneOn = 1'b0;
    nxt_s.detArm = 1'b0;
    // straps cross in through two flops
    nxt_s.priS1 = spanPri;
    nxt_s.priS2 = s_ff.priS1;
    case (s_ff.st)
      tdmtsa_pkg::ST_CLEAR: begin
        // wipe connections so nothing drives after reset
        memWe = 1'b1;
        memAddr = s_ff.clrAddr;
        memData = '0;
        nxt_s.clrAddr = s_ff.clrAddr + 12'h001;
        if (s_ff.clrAddr == tdmtsa_pkg::CONN_LAST) begin
          nxt_s.st = tdmtsa_pkg::ST_IDLE;
        end
      end
      tdmtsa_pkg::ST_IDLE: begin
        if (cmdValid) begin
          nxt_s.st = tdmtsa_pkg::ST_EXEC;
          nxt_s.op = cmdOp;
          nxt_s.port = cmdPort;
          nxt_s.strm = cmdStream;
          nxt_s.slot = cmdSlot;
          nxt_s.cnt = cmdCount;
          nxt_s.en = cmdEnable || (cmdOp == tdmtsa_pkg::OP_DETECT);
          nxt_s.rate = cmdRate;
          nxt_s.mode = cmdMode;
        end
      end
      tdmtsa_pkg::ST_EXEC: begin
        nxt_s.st = tdmtsa_pkg::ST_IDLE;
        case (s_ff.op)
          tdmtsa_pkg::OP_RESERVE: begin
            // one-digit stream only; failures leave the old base
            if (rngOk && !s_ff.strm[4]) begin
              nxt_s.baseOk = 1'b1;
              nxt_s.baseStrm = s_ff.strm[3:0];
              nxt_s.baseSlot = s_ff.slot;
              nxt_s.resCnt = s_ff.cnt;
              nxt_s.done = 1'b1;
            end else begin
              nxt_s.rej = 1'b1;
            end
          end
          tdmtsa_pkg::OP_QUERY: begin
            if (!chanOk) begin
              nxt_s.rej = 1'b1;
            end else if (!rspInReady) begin
              nxt_s.st = tdmtsa_pkg::ST_EXEC; // reply fifo full: hold
            end else begin
              nxt_s.done = 1'b1;
            end
          end
          tdmtsa_pkg::OP_RATE: begin
            // host picks the lower-stream rate before interworking
            if (s_ff.rate <= tdmtsa_pkg::RATE_8M &&
                s_ff.mode <= tdmtsa_pkg::MODE_HS_FULL) begin
              // paired and compat buses pin the low streams at 2.048
              case (s_ff.mode)
                tdmtsa_pkg::MODE_SC16: nxt_s.lowRate = s_ff.rate;
                tdmtsa_pkg::MODE_PAIRED16, tdmtsa_pkg::MODE_HS_COMPAT: begin
                  nxt_s.lowRate = tdmtsa_pkg::RATE_2M;
                end
                default: nxt_s.lowRate = tdmtsa_pkg::RATE_8M;
              endcase
              nxt_s.busMode = s_ff.mode;
              nxt_s.done = 1'b1;
            end else begin
              nxt_s.rej = 1'b1;
            end
          end
          tdmtsa_pkg::OP_OUTPUT, tdmtsa_pkg::OP_DETECT: begin
            if (chanOk && rngOk && !collide) begin
              memWe = 1'b1;
              nxt_s.done = 1'b1;
              nxt_s.resPort = s_ff.port;
              // detect also plays dial tone and arms a detector
              nxt_s.toneOn = (s_ff.op == tdmtsa_pkg::OP_DETECT);
              nxt_s.detArm = (s_ff.op == tdmtsa_pkg::OP_DETECT);
            end else begin
              nxt_s.rej = 1'b1;
            end
          end
          default: nxt_s.rej = 1'b1;
        endcase
      end
      default: nxt_s.st = tdmtsa_pkg::ST_CLEAR;
    endcase
    // advance scan; a position left out of range by a mode change
    // ends its row at once, but that stale slot still reaches the bus for one cycle
    if (scanSlot >= 7'((8'h01 << scanShift) - 8'h01) ||
        {1'b0, scanStrm} >= tdmtsa_pkg::streamLimit(s_ff.busMode)) begin
      nxt_s.scanPos[6:0] = 7'h00;
      if ({1'b0, scanStrm} + 6'h01 >=
          tdmtsa_pkg::streamLimit(s_ff.busMode)) begin
        nxt_s.scanPos[11:7] = 5'h00;
      end else begin
        nxt_s.scanPos[11:7] = scanStrm + 5'h01;
      end
    end else begin
      nxt_s.scanPos[6:0] = scanSlot + 7'h01;
    end
    nxt_s.txPos = s_ff.scanPos;
    nxt_s.txOe = scanRd[8] && (s_ff.st != tdmtsa_pkg::ST_CLEAR);
    nxt_s.txPort = scanRd[7:0];
    // shared memory words, zero elsewhere
    if (shmRd) begin
      if (shmAddr == tdmtsa_pkg::SHM_COUNT_ADDR) begin
        nxt_s.shmData = s_ff.resCnt;
      end else if (shmAddr == tdmtsa_pkg::SHM_BASE_ADDR) begin
        nxt_s.shmData = s_ff.baseOk ? 16'(baseAbs) : 16'h0000;
      end else begin
        nxt_s.shmData = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.lowRate <= tdmtsa_pkg::RATE_8M;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // connection table: enable bit and owning port per bus slot
  always_ff @(posedge clk) begin
    if (memWe) connMem[memAddr] <= memData;
  end

  // outputs
  assign cmdReady = (s_ff.st == tdmtsa_pkg::ST_IDLE);
  assign cmdDone = s_ff.done;
  assign cmdReject = s_ff.rej;
  assign {rspNone, rspPort, rspStream, rspSlot} = rspOutData;
  assign shmData = s_ff.shmData;
  assign toneOn = s_ff.toneOn;
  assign detArm = s_ff.detArm;
  assign resPort = s_ff.resPort;
  assign txStream = s_ff.txPos[11:7];
  assign txSlot = s_ff.txPos[6:0];
  assign txOe = s_ff.txOe;
  assign txPort = s_ff.txPort;
  assign lowRate = s_ff.lowRate;
  assign busMode = s_ff.busMode;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_take(logic [2:0] op);
    cmdValid && cmdReady && cmdOp == op;
  endsequence

  sequence s_good_reserve;
    isExec && s_ff.op == tdmtsa_pkg::OP_RESERVE && rngOk && !s_ff.strm[4];
  endsequence

  a_reserve_base: assert property (
    s_good_reserve |=> s_ff.baseOk && s_ff.baseSlot == $past(s_ff.slot)
  ) else $error("reserve did not store base");

  a_zone_reply: assert property (
    rspInValid && rspInReady |-> rspInData[20] == !s_ff.baseOk
  ) else $error("query reply Z flag wrong");

  a_reply_sum: assert property (
    rspInValid && s_ff.baseOk |->
      (13'({tgtStrm, 7'h00} >> (3'h7 - baseShift)) | 13'(tgtSlot)) ==
      baseAbs + 13'(s_ff.port)
  ) else $error("reply slot not base plus port");

  a_shm_count: assert property (
    shmRd && shmAddr == tdmtsa_pkg::SHM_COUNT_ADDR |=>
      shmData == $past(s_ff.resCnt)
  ) else $error("count word wrong");

  a_clear_quiet: assert property (
    s_ff.st == tdmtsa_pkg::ST_CLEAR |=> !txOe
  ) else $error("bus driven during clear");

  a_dchan_reject: assert property (
    s_take(tdmtsa_pkg::OP_QUERY) ##1 (s_ff.priS2[spanIdx] &&
      chan == tdmtsa_pkg::PRI_CHANS) |=> cmdReject && !cmdDone
  ) else $error("D-channel accepted");

  a_bad_range: assert property (
    isExec && s_ff.op == tdmtsa_pkg::OP_OUTPUT && !rngOk |=>
      cmdReject && $stable(s_ff.baseOk) && !$past(memWe)
  ) else $error("bad argument not rejected");

  a_rate_outcome: assert property (
    s_take(tdmtsa_pkg::OP_RATE) |-> ##2 (cmdDone ^ cmdReject)
  ) else $error("rate command outcome missing");

  a_legacy_streams: assert property (
    txOe && (busMode == tdmtsa_pkg::MODE_SC16 ||
             busMode == tdmtsa_pkg::MODE_PAIRED16) &&
      $stable(busMode)[*2] |-> txStream < 5'h10
  ) else $error("legacy bus used high stream");

  a_paired_slots: assert property (
    busMode == tdmtsa_pkg::MODE_PAIRED16 &&
      $past(busMode) == tdmtsa_pkg::MODE_PAIRED16 &&
      $past(busMode, 2) == tdmtsa_pkg::MODE_PAIRED16 &&
      txStream < 5'h10 |-> txSlot < 7'h20
  ) else $error("paired stream beyond 32 slots");

  a_detect_full: assert property (
    isExec && s_ff.op == tdmtsa_pkg::OP_DETECT && memWe |=>
      toneOn && detArm && resPort == $past(s_ff.port)
  ) else $error("detect did not arm resources");
endmodule : tdmtsa_top

// ===== verif/tdmtsa_host_model.sv
// Purpose: host side that drains query replies
// Assumes: a reply is taken where valid and ready meet
// Notes: stall holds ready low, slow drains every other cycle
`timescale 1ns/100ps
module tdmtsa_host_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // reply stream
  input wire logic rspValid,
  output logic rspReady,
  input wire logic rspNone,
  input wire logic [7:0] rspPort,
  input wire logic [4:0] rspStream,
  input wire logic [6:0] rspSlot,
  // pacing
  input wire logic stall,
  input wire logic slow
);
  logic [20:0] replies[$];
  // ready paced as a busy host app would
  always @(posedge clk or posedge rst) begin
    if (rst) rspReady <= 1'b0;
    else rspReady <= !stall && !(slow && rspReady);
  end
  // keep reply words in arrival order
  always @(posedge clk) begin
    if (!rst && rspValid === 1'b1 && rspReady === 1'b1)
      replies.push_back({rspNone, rspPort, rspStream, rspSlot});
  end
endmodule : tdmtsa_host_model

// ===== verif/tdmtsa_tb_top.sv
// Purpose: self-checking bench of the timeslot assigner
// Assumes: bus mode starts native at 8.192 MHz
// Notes: expected slots come from base plus port arithmetic
`timescale 1ns/100ps
module tdmtsa_tb_top;
  localparam int BASE = 1 * 64 + 'h24; // stream 1 slot 24h, 64 slots
  localparam logic [2:0] RES = tdmtsa_pkg::OP_RESERVE;
  localparam logic [2:0] QRY = tdmtsa_pkg::OP_QUERY;
  localparam logic [2:0] RATE = tdmtsa_pkg::OP_RATE;
  localparam logic [2:0] OUT = tdmtsa_pkg::OP_OUTPUT;
  localparam logic [2:0] DET = tdmtsa_pkg::OP_DETECT;
  // stimulus
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] spanPri = 8'h01; // span 0 primary rate
  logic cmdValid = 1'b0;
  logic [2:0] cmdOp = 3'h0;
  logic [7:0] cmdPort = 8'h00;
  logic [4:0] cmdStream = 5'h00;
  logic [6:0] cmdSlot = 7'h00;
  logic [15:0] cmdCount = 16'h0030;
  logic cmdEnable = 1'b0;
  logic [1:0] cmdRate = 2'h0;
  logic [2:0] cmdMode = 3'h0;
  logic shmRd = 1'b0;
  logic [12:0] shmAddr = 13'h0000;
  logic rspStall = 1'b0;
  logic rspSlow = 1'b0;
  // observed
  logic cmdReady, cmdDone, cmdReject, rspValid, rspReady, rspNone;
  logic toneOn, detArm, txOe;
  logic [7:0] rspPort, resPort, txPort;
  logic [4:0] rspStream, txStream;
  logic [6:0] rspSlot, txSlot;
  logic [15:0] shmData;
  logic [1:0] lowRate;
  logic [2:0] busMode;
  logic [20:0] rsp;
  logic [9:0] lastRes;
  logic ok;
  int failCount = 0;
  int checks = 0;
  int doneCnt = 0;
  int k, abs, held;
  logic [7:0] ports [7] = '{8'h00, 8'h16, 8'h17, 8'h18, 8'h20, 8'h37, 8'h38};
  logic [2:0] modes [4] = '{3'h2, 3'h3, 3'h4, 3'h0};
  logic [1:0] rates [4] = '{2'h0, 2'h0, 2'h2, 2'h2};

  // 50 ns clock and completion count
  always #25 clk = ~clk;
  always @(posedge clk) if (cmdDone === 1'b1) doneCnt++;

  tdmtsa_top u_dut (.clk, .rst, .spanPri, .cmdValid, .cmdReady, .cmdOp,
    .cmdPort, .cmdStream, .cmdSlot, .cmdCount, .cmdEnable, .cmdRate,
    .cmdMode, .cmdDone, .cmdReject, .rspValid, .rspReady, .rspNone,
    .rspPort, .rspStream, .rspSlot, .shmRd, .shmAddr, .shmData, .toneOn,
    .detArm, .resPort, .txStream, .txSlot, .txOe, .txPort, .lowRate,
    .busMode);
  tdmtsa_host_model u_host (.clk, .rst, .rspValid, .rspReady, .rspNone,
    .rspPort, .rspStream, .rspSlot, .stall(rspStall), .slow(rspSlow));

  task automatic tallyAndFinish;
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tallyAndFinish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      failCount++;
    end
  endtask : chk

  task automatic hang;
    failCount++;
    $display("ERROR at %0t: wait ran out", $time);
    tallyAndFinish();
  endtask : hang

  // one command: hold valid until taken, then wait for its outcome
  task automatic cmd(input logic [2:0] op, input logic [7:0] p,
                     input logic [4:0] s, input logic [6:0] t,
                     input logic en, input logic [1:0] r,
                     input logic [2:0] m, input logic rej);
    int i;
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdOp <= op;
    cmdPort <= p;
    cmdStream <= s;
    cmdSlot <= t;
    cmdEnable <= en;
    cmdRate <= r;
    cmdMode <= m;
    @(negedge clk);
    for (i = 0; i < 5000 && cmdReady !== 1'b1; i++) @(negedge clk);
    if (i == 5000) hang();
    @(posedge clk);
    cmdValid <= 1'b0;
    @(negedge clk);
    for (i = 0; i < 50 && cmdDone !== 1'b1 && cmdReject !== 1'b1; i++)
      @(negedge clk);
    if (i == 50) hang();
    lastRes = {toneOn, detArm, resPort};
    chk(32'(cmdReject), 32'(rej));
  endtask : cmd

  task automatic shm(input logic [12:0] a, input logic [15:0] exp);
    @(posedge clk);
    shmRd <= 1'b1;
    shmAddr <= a;
    @(posedge clk);
    shmRd <= 1'b0;
    @(negedge clk);
    chk(32'(shmData), 32'(exp));
  endtask : shm

  task automatic getRsp;
    int i;
    for (i = 0; i < 50 && u_host.replies.size() == 0; i++) @(negedge clk);
    if (i == 50) hang();
    rsp = u_host.replies.pop_front();
  endtask : getRsp

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    cmd(QRY, 8'h00, 5'h00, 7'h00, 1'b0, 2'h0, 3'h0, 1'b0);
    getRsp();
    chk(32'(rsp[20:12]), 32'h100);
    shm(13'h1f10, 16'h0000);
    shm(13'h1f12, 16'h0000);
    cmd(OUT, 8'h00, 5'h1f, 7'h7f, 1'b0, 2'h0, 3'h0, 1'b0);
    // a second talker on an owned slot is refused
    cmd(OUT, 8'h01, 5'h02, 7'h05, 1'b1, 2'h0, 3'h0, 1'b0);
    cmd(OUT, 8'h02, 5'h02, 7'h05, 1'b1, 2'h0, 3'h0, 1'b1);
    cmd(3'h5, 8'h00, 5'h00, 7'h00, 1'b0, 2'h0, 3'h0, 1'b1);
    cmd(RATE, 8'h00, 5'h00, 7'h00, 1'b0, 2'h1, 3'h1, 1'b0);
    chk(32'({busMode, lowRate}), 32'({3'h1, 2'h1}));
    cmd(OUT, 8'h00, 5'h10, 7'h00, 1'b0, 2'h0, 3'h0, 1'b1);
    cmd(OUT, 8'h00, 5'h00, 7'h40, 1'b0, 2'h0, 3'h0, 1'b1);
    cmd(OUT, 8'h00, 5'h00, 7'h3f, 1'b0, 2'h0, 3'h0, 1'b0);
    cmd(RES, 8'h00, 5'h01, 7'h24, 1'b0, 2'h0, 3'h0, 1'b0);
    cmd(RES, 8'h00, 5'h01, 7'h40, 1'b0, 2'h0, 3'h0, 1'b1);
    cmd(RES, 8'h00, 5'h10, 7'h00, 1'b0, 2'h0, 3'h0, 1'b1);
    shm(13'h1f10, 16'h0030);
    shm(13'h1f12, 16'(BASE));
    shm(13'h1f14, 16'h0000);
    // channel limits per span and base plus port replies
    for (k = 0; k < 7; k++) begin
      ok = ports[k][4:0] < (spanPri[ports[k][7:5]] ?
           tdmtsa_pkg::PRI_CHANS : tdmtsa_pkg::T1_CHANS);
      cmd(QRY, ports[k], 5'h00, 7'h00, 1'b0, 2'h0, 3'h0, !ok);
      if (ok) begin
        abs = BASE + ports[k];
        getRsp();
        chk(32'(rsp), {12'h0, ports[k], 5'(abs / 64), 7'(abs % 64)});
      end
    end
    chk(32'(u_host.replies.size()), 32'h0);
    // explicit slot is ignored once a base exists
    cmd(OUT, 8'h03, 5'h00, 7'h10, 1'b1, 2'h0, 3'h0, 1'b0);
    abs = BASE + 3;
    // skip the slot scanned before the table write landed
    @(negedge clk);
    for (k = 0; k < 3000 && !(txStream === 5'(abs / 64) &&
         txSlot === 7'(abs % 64)); k++) @(negedge clk);
    if (k == 3000) hang();
    chk(32'({txOe, txPort}), 32'h103);
    @(negedge clk);
    chk(32'(txOe), 32'h0);
    cmd(DET, 8'h05, 5'h00, 7'h00, 1'b0, 2'h0, 3'h0, 1'b0);
    chk(32'(lastRes), 32'h305);
    // fill the reply fifo, then hold one query behind it
    @(posedge clk);
    rspStall <= 1'b1;
    for (k = 0; k < 4; k++)
      cmd(QRY, 8'h00, 5'h00, 7'h00, 1'b0, 2'h0, 3'h0, 1'b0);
    // last done pulse is counted on the edge after the task returns
    @(negedge clk);
    held = doneCnt;
    fork
      cmd(QRY, 8'h01, 5'h00, 7'h00, 1'b0, 2'h0, 3'h0, 1'b0);
      begin
        repeat (10) @(negedge clk);
        chk(32'(doneCnt), 32'(held));
        @(posedge clk);
        rspStall <= 1'b0;
        rspSlow <= 1'b1;
      end
    join
    for (k = 0; k < 5; k++) begin
      getRsp();
      chk(32'(rsp[19:12]), 32'(k == 4));
    end
    // bus modes and the low stream rates they force
    for (k = 0; k < 4; k++) begin
      cmd(RATE, 8'h00, 5'h00, 7'h00, 1'b0, 2'h1, modes[k], 1'b0);
      chk(32'({busMode, lowRate}), 32'({modes[k], rates[k]}));
    end
    cmd(RATE, 8'h00, 5'h00, 7'h00, 1'b0, 2'h3, 3'h1, 1'b1);
    cmd(RATE, 8'h00, 5'h00, 7'h00, 1'b0, 2'h1, 3'h5, 1'b1);
    chk(32'({busMode, lowRate}), 32'({3'h0, 2'h2}));
    tallyAndFinish();
  end
endmodule : tdmtsa_tb_top
